// ===== inc/sfp_consts.vh
/*
 * Constants for the serial flash program/erase/sleep sequencer:
 * opcodes, geometry, cycle times and their cycle counts.
 * Assumes a 10 MHz core clock; times are in nanoseconds.
 */
`ifndef SFP_CONSTS_VH
`define SFP_CONSTS_VH

`define SFP_CLK_PERIOD_NS      100
`define SFP_OP_WRITE_ENABLE    8'h06
`define SFP_OP_QUAD_PROGRAM    8'h32
`define SFP_OP_SECTOR_ERASE    8'h20
`define SFP_OP_BLOCK32_ERASE   8'h52
`define SFP_OP_BLOCK64_ERASE   8'hd8
`define SFP_OP_ARRAY_ERASE_A   8'h60
`define SFP_OP_ARRAY_ERASE_B   8'hc7
`define SFP_OP_DEEP_SLEEP      8'hb9
`define SFP_OP_WAKE_ID         8'hab
`define SFP_PAGE_BYTES         256
`define SFP_QE_BIT             9
`define SFP_ADDR_BITS          24
`define SFP_SECTOR_SHIFT       12
`define SFP_BLOCK32_SHIFT      15
`define SFP_BLOCK64_SHIFT      16
`define SFP_RESET_WEL          1'b0
`define SFP_RESET_WIP          1'b0
`define SFP_RESET_SLEEP        1'b0
`define SFP_PROGRAM_TIME_NS    500000
`define SFP_SECTOR_TIME_NS     30000000
`define SFP_BLOCK_TIME_NS      150000000
`define SFP_ARRAY_TIME_NS      1000000000
`define SFP_SLEEP_DELAY_NS     3000
`define SFP_WAKE_DELAY_NS      8000
`define SFP_PROGRAM_CYC  ((`SFP_PROGRAM_TIME_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)
`define SFP_SECTOR_CYC   ((`SFP_SECTOR_TIME_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)
`define SFP_BLOCK_CYC    ((`SFP_BLOCK_TIME_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)
`define SFP_ARRAY_CYC    ((`SFP_ARRAY_TIME_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)
`define SFP_SLEEP_CYC    ((`SFP_SLEEP_DELAY_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)
`define SFP_WAKE_CYC     ((`SFP_WAKE_DELAY_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)

`endif

// ===== rtl/sfp_sync.v
/*
 * Two-flop synchroniser for a bundle of levels from outside the core clock.
 * Assumes inputs may change at any time relative to clk.
 */
`timescale 1ns/1ps
module sfp_sync #(
	parameter W = 1
) (
	// clock and reset
	input  wire         clk,
	input  wire         reset,
	// levels
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	always @(posedge clk) begin
		if (reset) begin
			meta_ff <= {W{1'b1}};
			sync_ff <= {W{1'b1}};
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;
endmodule // sfp_sync

// ===== rtl/sfp_flash_seq.v
/*
 * Serial flash command sequencer: quad page program, sector/32K/64K block
 * erase, whole-array erase, deep sleep and wake. Decodes the serial link
 * by oversampling the host clock with the core clock, and drives a memory
 * write/erase port plus busy status.
 * Assumes CLK at least 4x the serial clock; the status register bits
 * (quad enable, protection) arrive as plain inputs from status logic.
 */
`timescale 1ns/1ps
`include "sfp_consts.vh"
module sfp_flash_seq #(
	parameter PROGRAM_CYC = `SFP_PROGRAM_CYC,
	parameter SECTOR_CYC  = `SFP_SECTOR_CYC,
	parameter BLOCK_CYC   = `SFP_BLOCK_CYC,
	parameter ARRAY_CYC   = `SFP_ARRAY_CYC,
	parameter SLEEP_CYC   = `SFP_SLEEP_CYC,
	parameter WAKE_CYC    = `SFP_WAKE_CYC
) (
	// clock and reset
	input  wire        CLK,
	input  wire        RESET,
	// serial link from host
	input  wire        CS_N,
	input  wire        SCLK,
	input  wire [3:0]  IO_IN,
	// status bits from the status register
	input  wire [15:0] STATUS_IN,
	input  wire        PROTECT_HIT,
	// memory array port
	output reg         MEM_WE,
	output reg  [23:0] MEM_ADDR,
	output reg  [7:0]  MEM_WDATA,
	output reg         MEM_ERASE,
	output reg  [1:0]  MEM_ERASE_KIND,
	output reg  [23:0] MEM_ERASE_ADDR,
	output reg  [23:0] PROTECT_ADDR,
	// status out
	output wire        WRITE_IN_PROGRESS,
	output wire        WRITE_ENABLE_LATCH,
	output wire        DEEP_SLEEP,
	output wire        WAKE_PENDING
);
	localparam ST_IDLE = 2'd0;
	localparam ST_BUSY = 2'd1;
	localparam ST_SLP  = 2'd2;
	localparam ST_WAKE = 2'd3;
	localparam [1:0] K_SECTOR = 2'd0;
	localparam [1:0] K_B32    = 2'd1;
	localparam [1:0] K_B64    = 2'd2;
	localparam [1:0] K_ARRAY  = 2'd3;
	localparam [3:0] PROT_ALL_CLEAR = 4'h0;
	localparam [3:0] PROT_ALL_SET   = 4'hf;

	wire [5:0] sync_q;
	wire       cs_n_s = sync_q[5];
	wire       sclk_s = sync_q[4];
	wire [3:0] io_s   = sync_q[3:0];

	sfp_sync #(.W(6)) u_sync (
		.clk   (CLK),
		.reset (RESET),
		.d     ({CS_N, SCLK, IO_IN}),
		.q     (sync_q)
	);

	reg        sclk_d_ff;
	reg        cs_d_ff;
	reg [7:0]  shift_ff;
	reg [2:0]  bit_ff;
	reg [9:0]  byte_ff;
	reg [7:0]  op_ff;
	reg [23:0] addr_ff;
	reg        quad_ff;
	reg        wel_ff;
	reg [1:0]  st_ff;
	reg [31:0] cnt_ff;
	reg        prog_ok_ff;
	reg [1:0]  pend_kind_ff;
	reg        pend_erase_ff;
	reg        wel_cleared_ff;
	reg [7:0]  page_buf [0:`SFP_PAGE_BYTES-1];
	reg        page_mask_ff [0:`SFP_PAGE_BYTES-1];
	reg        flush_ff;
	reg [8:0]  flush_idx_ff;

	wire       rise    = sclk_s & ~sclk_d_ff & ~cs_n_s;
	wire       cs_rise = cs_n_s & ~cs_d_ff;
	wire [3:0] step    = quad_ff ? 4'd4 : 4'd1;
	wire [2:0] bits_after = bit_ff + step[2:0];
	wire [7:0] nxt_shift  = quad_ff ? {shift_ff[3:0], io_s} : {shift_ff[6:0], io_s[0]};
	wire       byte_done  = rise & (bits_after == 3'd0);
	wire       aligned    = (bit_ff == 3'd0);
	wire       busy       = (st_ff == ST_BUSY);
	wire [3:0] bp_cmp     = {STATUS_IN[14], STATUS_IN[4:2]};
	wire       prog_go;   // decoded below, needed by the page buffer

	integer i;

	// serial deserialiser
	always @(posedge CLK) begin
		if (RESET) begin
			sclk_d_ff <= 1'b0;
			cs_d_ff   <= 1'b1;
			shift_ff  <= 8'h00;
			bit_ff    <= 3'd0;
			byte_ff   <= 10'd0;
			op_ff     <= 8'h00;
			addr_ff   <= 24'h000000;
			quad_ff   <= 1'b0;
		end else begin
			sclk_d_ff <= sclk_s;
			cs_d_ff   <= cs_n_s;
			if (cs_n_s) begin
				bit_ff  <= 3'd0;
				byte_ff <= 10'd0;
				quad_ff <= 1'b0;
			end else if (rise) begin
				shift_ff <= nxt_shift;
				bit_ff   <= bits_after;
				if (byte_done) begin
					if (byte_ff != 10'h3ff)
						byte_ff <= byte_ff + 10'd1;
					if (byte_ff == 10'd0)
						op_ff <= nxt_shift;
					else if (byte_ff <= 10'd3)
						addr_ff <= {addr_ff[15:0], nxt_shift};
					// data phase goes quad only with quad_enable set
					if (byte_ff == 10'd3 && op_ff == `SFP_OP_QUAD_PROGRAM &&
					    STATUS_IN[`SFP_QE_BIT])
						quad_ff <= 1'b1;
				end
			end
		end
	end

	// page buffer: byte n lands at (start + n) mod 256, so later bytes overwrite
	always @(posedge CLK) begin
		if (RESET) begin
			for (i = 0; i < `SFP_PAGE_BYTES; i = i + 1)
				page_mask_ff[i] <= 1'b0;
		end else if (cs_n_s && !cs_d_ff && !flush_ff) begin
			for (i = 0; i < `SFP_PAGE_BYTES; i = i + 1)
				page_mask_ff[i] <= page_mask_ff[i] & prog_go;
		end else if (flush_ff && flush_idx_ff[8]) begin
			for (i = 0; i < `SFP_PAGE_BYTES; i = i + 1)
				page_mask_ff[i] <= 1'b0;
		end else if (byte_done && byte_ff >= 10'd4 && quad_ff && st_ff == ST_IDLE) begin
			page_buf[addr_ff[7:0] + byte_ff[7:0] - 8'd4] <= nxt_shift;
			page_mask_ff[addr_ff[7:0] + byte_ff[7:0] - 8'd4] <= 1'b1;
		end
	end

	// command qualification at select rise
	wire is_prog  = (op_ff == `SFP_OP_QUAD_PROGRAM) && quad_ff;
	wire is_se    = (op_ff == `SFP_OP_SECTOR_ERASE);
	wire is_b32   = (op_ff == `SFP_OP_BLOCK32_ERASE);
	wire is_b64   = (op_ff == `SFP_OP_BLOCK64_ERASE);
	wire is_ce    = (op_ff == `SFP_OP_ARRAY_ERASE_A) || (op_ff == `SFP_OP_ARRAY_ERASE_B);
	wire one_byte = (byte_ff == 10'd1);
	wire frame_ok = cs_rise & aligned & (st_ff == ST_IDLE);
	assign prog_go = frame_ok & is_prog & (byte_ff >= 10'd5) & wel_ff & ~PROTECT_HIT;
	wire erase_go = frame_ok & (is_se | is_b32 | is_b64) & (byte_ff == 10'd4) &
	                wel_ff & ~PROTECT_HIT;
	wire ce_go    = frame_ok & is_ce & one_byte & wel_ff &
	                ((bp_cmp == PROT_ALL_CLEAR) | (bp_cmp == PROT_ALL_SET));
	wire write_enable_cmd_go  = frame_ok & (op_ff == `SFP_OP_WRITE_ENABLE) & one_byte;
	wire sleep_go = frame_ok & (op_ff == `SFP_OP_DEEP_SLEEP) & one_byte;
	wire wake_go  = cs_rise & aligned & (st_ff == ST_SLP) &
	                (op_ff == `SFP_OP_WAKE_ID) & (byte_ff != 10'd0);

	// protection lookup address follows the decoded address
	always @(posedge CLK) begin
		if (RESET)
			PROTECT_ADDR <= 24'h000000;
		else
			PROTECT_ADDR <= addr_ff;
	end

	// cycle sequencer
	always @(posedge CLK) begin
		if (RESET) begin
			st_ff          <= ST_IDLE;
			cnt_ff         <= 32'd0;
			wel_ff         <= `SFP_RESET_WEL;
			prog_ok_ff     <= 1'b0;
			pend_kind_ff   <= K_SECTOR;
			pend_erase_ff  <= 1'b0;
			wel_cleared_ff <= 1'b0;
			flush_ff       <= 1'b0;
			flush_idx_ff   <= 9'd0;
			MEM_WE         <= 1'b0;
			MEM_ADDR       <= 24'h000000;
			MEM_WDATA      <= 8'h00;
			MEM_ERASE      <= 1'b0;
			MEM_ERASE_KIND <= K_SECTOR;
			MEM_ERASE_ADDR <= 24'h000000;
		end else begin
			MEM_WE    <= 1'b0;
			MEM_ERASE <= 1'b0;
			case (st_ff)
				ST_IDLE: begin
					if (write_enable_cmd_go)
						wel_ff <= 1'b1;
					if (prog_go) begin
						st_ff        <= ST_BUSY;
						cnt_ff       <= PROGRAM_CYC;
						prog_ok_ff   <= 1'b1;
						// page held here: a frame sent while busy may reload the address
						MEM_ADDR     <= {addr_ff[23:8], 8'h00};
						flush_ff     <= 1'b1;
						flush_idx_ff <= 9'd0;
						wel_cleared_ff <= 1'b0;
					end else if (erase_go | ce_go) begin
						st_ff          <= ST_BUSY;
						pend_erase_ff  <= 1'b1;
						wel_cleared_ff <= 1'b0;
						prog_ok_ff     <= 1'b0;
						if (ce_go) begin
							pend_kind_ff <= K_ARRAY;
							cnt_ff       <= ARRAY_CYC;
						end else if (is_se) begin
							pend_kind_ff <= K_SECTOR;
							cnt_ff       <= SECTOR_CYC;
						end else if (is_b32) begin
							pend_kind_ff <= K_B32;
							cnt_ff       <= BLOCK_CYC;
						end else begin
							pend_kind_ff <= K_B64;
							cnt_ff       <= BLOCK_CYC;
						end
						MEM_ERASE_ADDR <= addr_ff;
					end else if (sleep_go) begin
						st_ff  <= ST_SLP;
						cnt_ff <= SLEEP_CYC;
					end
				end
				ST_BUSY: begin
					// latch drops on the first busy cycle, well before the end
					if (!wel_cleared_ff) begin
						wel_ff         <= 1'b0;
						wel_cleared_ff <= 1'b1;
					end
					if (pend_erase_ff) begin
						MEM_ERASE      <= 1'b1;
						MEM_ERASE_KIND <= pend_kind_ff;
						pend_erase_ff  <= 1'b0;
					end
					// only bytes actually sent are written back
					if (flush_ff) begin
						if (flush_idx_ff[8]) begin
							flush_ff <= 1'b0;
						end else begin
							if (page_mask_ff[flush_idx_ff[7:0]]) begin
								MEM_WE    <= 1'b1;
								MEM_ADDR  <= {MEM_ADDR[23:8], flush_idx_ff[7:0]};
								MEM_WDATA <= page_buf[flush_idx_ff[7:0]];
							end
							flush_idx_ff <= flush_idx_ff + 9'd1;
						end
					end
					if (cnt_ff <= 32'd1 && !flush_ff) begin
						st_ff      <= ST_IDLE;
						prog_ok_ff <= 1'b0;
					end else if (cnt_ff > 32'd1) begin
						cnt_ff <= cnt_ff - 32'd1;
					end
				end
				ST_SLP: begin
					if (cnt_ff != 32'd0)
						cnt_ff <= cnt_ff - 32'd1;
					if (wake_go) begin
						st_ff  <= ST_WAKE;
						cnt_ff <= WAKE_CYC;
					end
				end
				ST_WAKE: begin
					// commands refused until the wake delay has run out
					if (cnt_ff <= 32'd1)
						st_ff <= ST_IDLE;
					else
						cnt_ff <= cnt_ff - 32'd1;
				end
				default: st_ff <= ST_IDLE;
			endcase
		end
	end

	assign WRITE_IN_PROGRESS  = busy;
	assign WRITE_ENABLE_LATCH = wel_ff;
	assign DEEP_SLEEP         = (st_ff == ST_SLP) && (cnt_ff == 32'd0);
	assign WAKE_PENDING       = (st_ff == ST_WAKE);
endmodule // sfp_flash_seq

// ===== bench/sfp_host.sv
/* Host model: drives select, serial clock and the four data lines.
   Assumes the bench clock; the serial clock half period is four of its cycles. */
`timescale 1ns/1ps
module sfp_host (
	// bench clock
	input  wire        clk,
	// serial link
	output logic       cs_n,
	output logic       sclk,
	output logic [3:0] io
);
	logic [7:0] bq[$];
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		io = 4'h0;
	end
	task automatic half();
		repeat (4) @(negedge clk);
	endtask
	// data set while the clock is low, taken on its rise
	task automatic bit_out(input logic [3:0] v);
		io = v;
		half();
		sclk = 1'b1;
		half();
		sclk = 1'b0;
	endtask
	// first ns bytes on io_line_0, the rest in nibbles; cut adds one more clock, half a byte in nibbles
	task automatic send(input int ns, input bit cut);
		logic [7:0] b;
		int i;
		int k;
		cs_n = 1'b0;
		half();
		for (i = 0; bq.size() > 0; i++) begin
			b = bq.pop_front();
			if (i < ns)
				for (k = 7; k >= 0; k--) bit_out({~io[3:1], b[k]});
			else begin
				bit_out(b[7:4]);
				bit_out(b[3:0]);
			end
		end
		if (cut)
			bit_out(~io);
		io = ~io;
		cs_n = 1'b1;
		// released lines show the inverse; the bench waits 32 cycles, past the sleep delay
		repeat (8) half();
	endtask
endmodule // sfp_host

// ===== bench/sfp_flash_seq_props.sv
/* Checker for the sequencer's status and memory strobes.
   Bound to sfp_flash_seq; sees only its ports. */
`timescale 1ns/1ps
module sfp_flash_seq_props #(
	parameter PROGRAM_CYC = 1, SECTOR_CYC = 1, BLOCK_CYC = 1,
	parameter ARRAY_CYC = 1, SLEEP_CYC = 1, WAKE_CYC = 1
) (
	// clock and reset
	input wire CLK,
	input wire RESET,
	// link and protection
	input wire CS_N,
	input wire PROTECT_HIT,
	// strobes and status
	input wire MEM_WE,
	input wire MEM_ERASE,
	input wire WRITE_IN_PROGRESS,
	input wire WRITE_ENABLE_LATCH,
	input wire DEEP_SLEEP,
	input wire WAKE_PENDING
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	int busy_ff;
	always @(posedge CLK)
		busy_ff <= (RESET || !WRITE_IN_PROGRESS) ? 0 : busy_ff + 1;
	sequence s_held4;
		WRITE_IN_PROGRESS [*4];
	endsequence
	sequence s_wel_drop;
		##[1:3] !WRITE_ENABLE_LATCH;
	endsequence
	chk_start_gated:
	assert property ($rose(WRITE_IN_PROGRESS) |-> $past(WRITE_ENABLE_LATCH) && CS_N && !PROTECT_HIT)
		else $error("busy started without latch or while protected");
	chk_latch_clears:
	assert property ($rose(WRITE_IN_PROGRESS) |-> s_wel_drop)
		else $error("write enable latch not cleared");
	chk_busy_holds:
	assert property ($rose(WRITE_IN_PROGRESS) |-> s_held4) else $error("busy too short");
	chk_busy_length:
	assert property ($fell(WRITE_IN_PROGRESS) |-> busy_ff >= SECTOR_CYC - 1)
		else $error("busy cycle ended early");
	chk_erase_pulse:
	assert property (MEM_ERASE |-> WRITE_IN_PROGRESS && !WRITE_ENABLE_LATCH ##1 !MEM_ERASE)
		else $error("erase strobe outside its cycle");
	chk_write_busy:
	assert property (MEM_WE |-> WRITE_IN_PROGRESS) else $error("array write while idle");
	chk_sleep_quiet:
	assert property (DEEP_SLEEP |-> $stable(WRITE_ENABLE_LATCH) && !WRITE_IN_PROGRESS &&
		!MEM_WE && !MEM_ERASE)
		else $error("activity in deep sleep");
	chk_sleep_delay:
	assert property ($rose(DEEP_SLEEP) |-> CS_N && $past(CS_N, 20)) else $error("sleep entered early");
	chk_wake_gate:
	assert property ($rose(WAKE_PENDING) |-> $past(DEEP_SLEEP) ##1 WAKE_PENDING [*8])
		else $error("wake delay wrong");
endmodule // sfp_flash_seq_props
bind sfp_flash_seq sfp_flash_seq_props #(.PROGRAM_CYC(PROGRAM_CYC), .SECTOR_CYC(SECTOR_CYC),
	.BLOCK_CYC(BLOCK_CYC), .ARRAY_CYC(ARRAY_CYC), .SLEEP_CYC(SLEEP_CYC), .WAKE_CYC(WAKE_CYC))
	i_props (.CLK(CLK), .RESET(RESET), .CS_N(CS_N), .PROTECT_HIT(PROTECT_HIT), .MEM_WE(MEM_WE),
	.MEM_ERASE(MEM_ERASE), .WRITE_IN_PROGRESS(WRITE_IN_PROGRESS),
	.WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .DEEP_SLEEP(DEEP_SLEEP), .WAKE_PENDING(WAKE_PENDING));

// ===== bench/sfp_flash_seq_tb.sv
/* Self-checking bench for sfp_flash_seq with the host model.
   Assumes the shortened cycle counts set at the instance; wake delay keeps its default. */
`timescale 1ns/1ps
module sfp_flash_seq_tb;
	logic        clk, reset, phit;
	logic [15:0] status;
	logic [31:0] lfsr = 32'hb293c67a;
	int          error_cnt = 0, tests_run = 0;
	wire         cs_n, sclk, mem_we, mem_erase, write_in_progress, write_enable_latch, ds, wp;
	wire  [3:0]  io;
	wire  [7:0]  mem_wdata;
	wire  [1:0]  mem_erase_kind;
	wire  [23:0] mem_addr, mem_erase_addr;
	logic [31:0] we_q[$];
	logic [25:0] er_q[$];
	logic [7:0]  pg[256];
	bit          pv[256];
	logic [23:0] a;
	logic [7:0]  ops[3] = '{8'h20, 8'h52, 8'hd8};
	sfp_host i_sfp_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .io(io));
	sfp_flash_seq #(.PROGRAM_CYC(40), .SECTOR_CYC(20), .BLOCK_CYC(30), .ARRAY_CYC(40),
		.SLEEP_CYC(20)) i_sfp_flash_seq (.CLK(clk), .RESET(reset), .CS_N(cs_n),
		.SCLK(sclk), .IO_IN(io), .STATUS_IN(status), .PROTECT_HIT(phit), .MEM_WE(mem_we),
		.MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_ERASE(mem_erase),
		.MEM_ERASE_KIND(mem_erase_kind), .MEM_ERASE_ADDR(mem_erase_addr), .PROTECT_ADDR(),
		.WRITE_IN_PROGRESS(write_in_progress), .WRITE_ENABLE_LATCH(write_enable_latch), .DEEP_SLEEP(ds), .WAKE_PENDING(wp));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function automatic logic [23:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[23:0];
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	// erase address only matters down to its region
	task automatic cmp_er(input logic [25:0] got, input logic [25:0] exp);
		int sh;
		sh = (exp[25:24] == 2'h0) ? 12 : (exp[25:24] == 2'h1) ? 15 : (exp[25:24] == 2'h2) ? 16 : 24;
		cmp({got[25:24], got[23:0] >> sh}, {exp[25:24], exp[23:0] >> sh});
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic idle();
		int n;
		for (n = 0; n < 4000 && (write_in_progress || wp); n++) @(negedge clk);
		if (write_in_progress || wp) begin
			error_cnt++;
			results();
		end
	endtask
	task automatic frame(input logic [7:0] op, input int na, input logic [23:0] ad,
		input int nd, input int ns, input bit cut);
		logic [7:0] d;
		int i;
		pv = '{default: 0};
		i_sfp_host.bq.push_back(op);
		for (i = 2; i >= 3 - na; i--) i_sfp_host.bq.push_back(ad[8*i +: 8]);
		for (i = 0; i < nd; i++) begin
			d = 8'(rnd());
			pg[ad[7:0] + i[7:0]] = d;
			pv[ad[7:0] + i[7:0]] = 1'b1;
			i_sfp_host.bq.push_back(d);
		end
		// array writes start before send returns, so expectations go first
		if (op == 8'h32 && !cut && status[9])
			for (i = 0; i < 256; i++)
				if (pv[i])
					we_q.push_back({ad[23:8], i[7:0], pg[i]});
		i_sfp_host.send(ns, cut);
	endtask
	task automatic write_enable_cmd();
		frame(8'h06, 0, 24'h0, 0, 8, 0);
	endtask
	task automatic prog(input logic [23:0] ad, input int nd, input bit cut);
		write_enable_cmd();
		frame(8'h32, 3, ad, nd, 4, cut);
		idle();
	endtask
	always @(negedge clk) begin
		if (mem_we === 1'b1)
			cmp({mem_addr, mem_wdata}, (we_q.size() > 0) ? we_q.pop_front() : 32'hx);
		if (mem_erase === 1'b1)
			cmp_er({mem_erase_kind, mem_erase_addr}, (er_q.size() > 0) ? er_q.pop_front() : 26'hx);
	end
	initial begin
		reset = 1'b1;
		status = 16'h0;
		phit = 1'b0;
		repeat (8) @(negedge clk);
		reset = 1'b0;
		repeat (3) @(negedge clk);
		cmp({write_in_progress, write_enable_latch, ds, wp}, 4'h0);
		frame(8'h20, 3, rnd(), 0, 8, 0);
		idle();
		cmp({write_in_progress, write_enable_latch}, 2'h0);
		for (int k = 0; k < 3; k++) begin
			a = rnd();
			write_enable_cmd();
			er_q.push_back({k[1:0], a});
			frame(ops[k], 3, a, 0, 8, 0);
			idle();
			cmp(write_enable_latch, 0);
		end
		phit = 1'b1;
		write_enable_cmd();
		frame(8'h52, 3, a, 0, 8, 0);
		idle();
		phit = 1'b0;
		cmp(write_enable_latch, 1);
		frame(8'h20, 3, a, 0, 8, 1);
		idle();
		cmp(write_enable_latch, 1);
		status = 16'h0008;
		frame(8'h60, 0, 24'h0, 0, 8, 0);
		idle();
		cmp(write_enable_latch, 1);
		status = 16'h401c;
		er_q.push_back({2'h3, 24'h0});
		frame(8'hc7, 0, 24'h0, 0, 8, 0);
		idle();
		status = 16'h0;
		write_enable_cmd();
		er_q.push_back({2'h3, 24'h0});
		frame(8'h60, 0, 24'h0, 0, 8, 0);
		idle();
		// quad program without quad_enable must not run
		write_enable_cmd();
		frame(8'h32, 3, a, 4, 4, 0);
		idle();
		cmp({write_in_progress, write_enable_latch}, 2'h1);
		status = 16'h0200;
		a = rnd();
		prog({a[23:8], 8'hf0}, 20, 0);
		prog(rnd(), 258, 0);
		prog(rnd(), 3, 1);
		cmp(write_enable_latch, 1);
		frame(8'hb9, 0, 24'h0, 0, 8, 0);
		cmp(ds, 1);
		write_enable_cmd();
		frame(8'hd8, 3, a, 0, 8, 0);
		cmp({ds, write_in_progress}, 2'h2);
		frame(8'hab, 0, 24'h0, 0, 8, 0);
		idle();
		cmp(ds, 0);
		write_enable_cmd();
		frame(8'h32, 3, a, 1, 4, 0);
		frame(8'hb9, 0, 24'h0, 0, 8, 0);
		idle();
		cmp(ds, 0);
		cmp(we_q.size() + er_q.size(), 0);
		results();
	end
endmodule // sfp_flash_seq_tb
